// File: verilog/adcth_top.sv
// Converter threshold trigger with AHB-Lite register slave and event interrupt
//
// Implementation choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
// What this block does
// - Channel 0 type bits 13..12, 00 never
// - Type 01: trigger while reading above threshold
// - Type 10: trigger while reading at/below threshold
// - Channel 0 threshold bits 11..0, compared
// - Channel 3 type bits 29..28, second register
// - Channel 3 decodes 00, 01, 10 likewise
// - Channel 3 threshold bits 27..16, compared
// - Channel 2 type field, same decoding
// - Combined output from per-channel trigger conditions
// - Channel 1 type 29..28, threshold 27..16
// - Channel 2 threshold bits 11..0, compared
module adcth_top
(
    input  wire logic                 mclk,
    input  wire logic                 rst,
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic                      hreadyout,
    output logic                      hresp,
    output logic [31:0]               hrdata,
    input  wire logic [3:0][11:0]     conv_reading,
    input  wire logic [3:0]           conv_valid,
    output logic [3:0]                channel_trigger,
    output logic                      combined_trigger,
    output logic                      irq
);

    // ----------------------------------------------------------------
    // Bus address phase capture
    // ----------------------------------------------------------------
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [31:0] ctrl_low_pair;
    logic [31:0] ctrl_high_pair;
    logic [4:0]  evt_status;
    logic [4:0]  evt_enable;
    logic [3:0][11:0] latest_reading;

    wire        xfer_sel   = hsel && hready && htrans[1];
    wire        rd_start   = xfer_sel && !hwrite;
    wire        wr_start   = xfer_sel && hwrite;
    wire [7:0]  rd_addr    = haddr[7:0];

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end
        else
        begin
            wr_pend <= wr_start;
            wr_addr <= {haddr[7:2], 2'b00};
        end
    end

    // ----------------------------------------------------------------
    // Write decode in the data phase
    // ----------------------------------------------------------------
    wire wr_low   = wr_pend && (wr_addr == adcth_pkg::OFS_CTRL_LOW_PAIR);
    wire wr_high  = wr_pend && (wr_addr == adcth_pkg::OFS_CTRL_HIGH_PAIR);
    wire wr_clear = wr_pend && (wr_addr == adcth_pkg::OFS_EVENT_CLEAR);
    wire wr_en    = wr_pend && (wr_addr == adcth_pkg::OFS_EVENT_ENABLE);

    // Masking at the store keeps reserved bits zero for every reader
    wire [31:0] next_ctrl_low  = wr_low  ? (hwdata & adcth_pkg::CTRL_WMASK) : ctrl_low_pair;
    wire [31:0] next_ctrl_high = wr_high ? (hwdata & adcth_pkg::CTRL_WMASK) : ctrl_high_pair;
    wire [4:0]  next_evt_enable = wr_en  ? hwdata[4:0] : evt_enable;

    // ----------------------------------------------------------------
    // Channel configuration unpacking
    // ----------------------------------------------------------------
    adcth_pkg::adcth_chan_cfg_t [3:0] chan_cfg;

    // Type field sits directly above its threshold, so one slice carries both
    localparam int CFG_W = adcth_pkg::THR_W + adcth_pkg::TYPE_W;

    assign chan_cfg[0] = adcth_pkg::adcth_chan_cfg_t'(ctrl_low_pair[adcth_pkg::LO_THR_POS +: CFG_W]);
    assign chan_cfg[1] = adcth_pkg::adcth_chan_cfg_t'(ctrl_low_pair[adcth_pkg::HI_THR_POS +: CFG_W]);
    assign chan_cfg[2] = adcth_pkg::adcth_chan_cfg_t'(ctrl_high_pair[adcth_pkg::LO_THR_POS +: CFG_W]);
    assign chan_cfg[3] = adcth_pkg::adcth_chan_cfg_t'(ctrl_high_pair[adcth_pkg::HI_THR_POS +: CFG_W]);

    // ----------------------------------------------------------------
    // Latest conversion reading per channel
    // ----------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        for (int i = 0; i < adcth_pkg::NUM_CH; i++)
        begin
            if (rst)
                latest_reading[i] <= 12'h000;
            else if (conv_valid[i])
                latest_reading[i] <= conv_reading[i];
        end
    end

    // ----------------------------------------------------------------
    // Threshold comparison
    // ----------------------------------------------------------------
    logic [3:0] chan_cond;

    genvar g;
    generate
        for (g = 0; g < adcth_pkg::NUM_CH; g++)
        begin : g_chan
            // Unsigned operands; type 11 falls to never
            wire above    = latest_reading[g] > chan_cfg[g].threshold;
            wire is_above = chan_cfg[g].trig_type == adcth_pkg::TRIG_ABOVE;
            wire is_below = chan_cfg[g].trig_type == adcth_pkg::TRIG_AT_BELOW;
            assign chan_cond[g] = (is_above && above) || (is_below && !above);
        end
    endgenerate

    // Any configured channel that is true fires the combined output
    wire next_combined = |chan_cond;

    // ----------------------------------------------------------------
    // Trigger outputs and events
    // ----------------------------------------------------------------
    wire [4:0] evt_set = {next_combined & ~combined_trigger, chan_cond & ~channel_trigger};
    // Set beats a clear landing in the same cycle
    wire [4:0] next_evt_status = (evt_status & ~(wr_clear ? hwdata[4:0] : 5'h00)) | evt_set;

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            ctrl_low_pair    <= adcth_pkg::CTRL_RESET;
            ctrl_high_pair   <= adcth_pkg::CTRL_RESET;
            evt_enable       <= adcth_pkg::EVT_RESET;
            evt_status       <= adcth_pkg::EVT_RESET;
            channel_trigger  <= 4'h0;
            combined_trigger <= 1'b0;
            irq              <= 1'b0;
        end
        else
        begin
            ctrl_low_pair    <= next_ctrl_low;
            ctrl_high_pair   <= next_ctrl_high;
            evt_enable       <= next_evt_enable;
            evt_status       <= next_evt_status;
            channel_trigger  <= chan_cond;
            combined_trigger <= next_combined;
            irq              <= |(next_evt_status & next_evt_enable);
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    // Muxing next values forwards a write that is finishing this cycle
    wire [7:0]  rd_word = {rd_addr[7:2], 2'b00};
    wire [31:0] rd_mux =
        (rd_word == adcth_pkg::OFS_CTRL_LOW_PAIR)  ? next_ctrl_low :
        (rd_word == adcth_pkg::OFS_CTRL_HIGH_PAIR) ? next_ctrl_high :
        (rd_word == adcth_pkg::OFS_EVENT_STATUS)   ? {27'h0, next_evt_status} :
        (rd_word == adcth_pkg::OFS_EVENT_ENABLE)   ? {27'h0, next_evt_enable} :
        (rd_word == adcth_pkg::OFS_TRIGGER_STATE)  ? {27'h0, next_combined, chan_cond} :
        32'h0000_0000;

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= adcth_pkg::HRESP_OKAY;
        end
        else
        begin
            hrdata    <= rd_start ? rd_mux : 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= adcth_pkg::HRESP_OKAY;
        end
    end

endmodule

// File: verilog/adcth_pkg.sv
// Package: register map, field layout and codes for the converter threshold trigger
package adcth_pkg;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL_LOW_PAIR  = 8'h00;
    localparam logic [7:0] OFS_CTRL_HIGH_PAIR = 8'h04;
    localparam logic [7:0] OFS_EVENT_STATUS   = 8'h08;
    localparam logic [7:0] OFS_EVENT_CLEAR    = 8'h0c;
    localparam logic [7:0] OFS_EVENT_ENABLE   = 8'h10;
    localparam logic [7:0] OFS_TRIGGER_STATE  = 8'h14;

    // ----------------------------------------------------------------
    // Field positions inside a control register
    // ----------------------------------------------------------------
    localparam int LO_THR_POS  = 0;
    localparam int LO_TYPE_POS = 12;
    localparam int HI_THR_POS  = 16;
    localparam int HI_TYPE_POS = 28;
    localparam int THR_W       = 12;
    localparam int TYPE_W      = 2;
    localparam int NUM_CH      = 4;
    localparam int NUM_EVT     = 5;

    // Writable bits; 31..30 and 15..14 are reserved
    localparam logic [31:0] CTRL_WMASK        = 32'h3fff_3fff;
    localparam logic [31:0] CTRL_RESET        = 32'h0000_0000;
    localparam logic [NUM_EVT-1:0] EVT_RESET  = 5'h00;
    localparam int          EVT_COMBINED_POS  = 4;

    // ----------------------------------------------------------------
    // Trigger type codes
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        TRIG_NEVER   = 2'h0,
        TRIG_ABOVE   = 2'h1,
        TRIG_AT_BELOW = 2'h2,
        TRIG_UNUSED  = 2'h3
    } adcth_type_t;

    typedef struct packed {
        adcth_type_t      trig_type;
        logic [THR_W-1:0] threshold;
    } adcth_chan_cfg_t;

    // AHB-Lite transfer types and response
    localparam logic [1:0] HTRANS_IDLE   = 2'h0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ    = 2'h3;
    localparam logic       HRESP_OKAY    = 1'b0;

endpackage

// File: tb/adcth_props.sv
// Checker: port-level properties of the converter threshold trigger
`timescale 1ns/1ps
module adcth_props
(
    input wire logic              mclk,
    input wire logic              rst,
    input wire logic              hsel,
    input wire logic [31:0]       haddr,
    input wire logic [1:0]        htrans,
    input wire logic              hwrite,
    input wire logic              hready,
    input wire logic              hreadyout,
    input wire logic              hresp,
    input wire logic [31:0]       hrdata,
    input wire logic [3:0]        conv_valid,
    input wire logic [3:0]        channel_trigger,
    input wire logic              combined_trigger,
    input wire logic              irq
);
    wire logic rd = hsel && hready && htrans[1] && !hwrite;
    wire logic wr = hsel && hready && htrans[1] && hwrite;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_ctrl_rd;
        rd && (haddr[7:2] < 6'h02);
    endsequence
    sequence s_new_cause;
        (|$past(conv_valid, 2)) || $past(wr, 3);
    endsequence
    a_comb_or: assert property (combined_trigger == |channel_trigger) else $error("combined not OR");
    a_bus_okay: assert property (hreadyout && !hresp) else $error("bus wait or error");
    a_rdata_idle: assert property (!rd |=> hrdata == 32'h0) else $error("stray read data");
    a_resv_zero: assert property (s_ctrl_rd |=> hrdata[31:30] == 2'h0 && hrdata[15:14] == 2'h0)
        else $error("reserved bits set");
    a_trig_cause: assert property (|(channel_trigger & ~$past(channel_trigger)) |-> s_new_cause)
        else $error("trigger rose without cause");
    a_irq_fall: assert property ($fell(irq) |-> $past(wr, 2) || $past(wr, 3)) else $error("irq fell alone");
    a_irq_cause: assert property ($rose(irq) |-> $rose(combined_trigger) || $past(wr, 2) || $past(wr, 3)
        || |(channel_trigger & ~$past(channel_trigger))) else $error("irq rose alone");
    a_reset_quiet: assert property (disable iff (1'b0) rst |=> !channel_trigger && !irq && hrdata == 32'h0)
        else $error("outputs active after reset");
endmodule
bind adcth_top adcth_props u_props (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .conv_valid(conv_valid), .channel_trigger(channel_trigger), .combined_trigger(combined_trigger), .irq(irq));

// File: tb/tb_top.sv
// Testbench: registers, trigger decoding and interrupt over AHB-Lite
`timescale 1ns/1ps
module tb_top;
    logic             mclk = 0, rst = 1, hsel = 0, hwrite = 0, hready, hreadyout, hresp, irq, e, rd_dp = 0;
    logic [31:0]      haddr = '0, hwdata = '0, hrdata, v;
    logic [1:0]       htrans = adcth_pkg::HTRANS_IDLE;
    logic [3:0][11:0] conv_reading = '0;
    logic [3:0]       conv_valid = '0, channel_trigger;
    logic [11:0]      t, r;
    logic [39:0]      n, notes[$];
    logic             combined_trigger;
    int               n_fail = 0, checks = 0, cyc = 0;
    logic [7:0]       ofs[7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20};
    assign hready = hreadyout;
    adcth_top dut (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .conv_reading(conv_reading), .conv_valid(conv_valid), .channel_trigger(channel_trigger),
        .combined_trigger(combined_trigger), .irq(irq));
    initial forever #4 mclk = ~mclk;
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s exp %h got %h", nm, exp, got);
        end
    endtask
    task give_verdict;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= adcth_pkg::HTRANS_NONSEQ; hwrite <= w;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= adcth_pkg::HTRANS_IDLE; hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] x);
        notes.push_back({a, x});
        xfer(1'b0, a, 32'h0);
    endtask
    task cv(input int ch, input logic [11:0] val);
        conv_reading[ch] <= val; conv_valid <= 4'h1 << ch;
        @(posedge mclk); conv_valid <= 4'h0;
        repeat (2) @(posedge mclk);
    endtask
    task irqchk(input logic x);
        repeat (2) @(posedge mclk);
        chk("irq", {31'h0, irq}, {31'h0, x});
    endtask
    // --------------------------------------------------------
    // Monitor: data-phase read results against oldest note
    // --------------------------------------------------------
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc > 20000)
        begin
            n_fail++;
            give_verdict;
        end
        if (rd_dp && hreadyout)
        begin
            n = notes.pop_front();
            chk($sformatf("read %h", n[39:32]), hrdata, n[31:0]);
        end
        if (hreadyout) rd_dp <= hsel && htrans[1] && !hwrite;
    end
    initial
    begin
        void'($urandom(18758));
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        xfer(1'b1, 8'h20, 32'hffff_ffff);
        foreach (ofs[i]) rd(ofs[i], 32'h0);
        xfer(1'b1, 8'h00, 32'hffff_ffff);
        xfer(1'b1, 8'h04, 32'hffff_ffff);
        rd(8'h00, 32'h3fff_3fff);
        rd(8'h04, 32'h3fff_3fff);
        rd(8'h14, 32'h0);
        for (int c = 0; c < 4; c++)
            for (int ty = 0; ty < 4; ty++)
            begin
                t = 12'($urandom_range(4095));
                v = c[0] ? {2'h0, 2'(ty), t, 16'h0} : {18'h0, 2'(ty), t};
                xfer(1'b1, c[1] ? 8'h04 : 8'h00, v);
                xfer(1'b1, c[1] ? 8'h00 : 8'h04, 32'h0);
                rd(c[1] ? 8'h04 : 8'h00, v);
                for (int k = 0; k < 3; k++)
                begin
                    r = t + 12'(k) - 12'h1;
                    cv(c, r);
                    e = (ty == 1 && r > t) || (ty == 2 && r <= t);
                    chk("channel_trigger", {28'h0, channel_trigger}, {28'h0, 4'(e) << c});
                    chk("combined_trigger", {31'h0, combined_trigger}, {31'h0, e});
                    rd(8'h14, {27'h0, e, 4'(e) << c});
                end
            end
        xfer(1'b1, 8'h0c, 32'h1f);
        xfer(1'b1, 8'h00, 32'h1000);
        cv(0, 12'h5);
        rd(8'h08, 32'h11);
        irqchk(1'b0);
        xfer(1'b1, 8'h10, 32'h1);
        irqchk(1'b1);
        rd(8'h0c, 32'h0);
        xfer(1'b1, 8'h0c, 32'h1);
        rd(8'h08, 32'h10);
        irqchk(1'b0);
        xfer(1'b1, 8'h10, 32'h1f);
        irqchk(1'b1);
        xfer(1'b1, 8'h0c, 32'h1f);
        irqchk(1'b0);
        rd(8'h08, 32'h0);
        repeat (3) @(posedge mclk);
        give_verdict;
    end
endmodule
